//--- hdl/ppe_regs.sv
/*
  Power path control and event flag/mask registers, reached by the host
  through an I2C slave on open-drain SCL/SDA pins, plus the active-low
  interrupt line.

  Register map seen through the serial pointer:
    0x01  power path control, read/write
          7    AC current-sink control
          6    USB current-sink control
          5    AC input on
          4    USB input on
          3:2  AC input-current limit, bit 2 held at one
          1:0  USB input-current limit, bit 0 held at one
    0x02  event flags and masks
          7    spare read/write bit, no function
          6    button event mask
          5    AC event mask
          4    USB event mask
          3    reads zero
          2    button change flag, read-only
          1    AC change flag, read-only
          0    USB change flag, read-only
    0x03  charger status byte, straight from its input pins
    0x0a  present levels: bit 3 AC valid, bit 2 USB valid,
          bit 0 push button
  Any other offset reads zero and ignores writes.

  Serial framing:
    Write: address with write bit, pointer byte, then data bytes.
    Read: set the pointer in a write frame, repeated start, then
    address with read bit; the host NACKs the last byte.
    The pointer steps after every data byte in either direction.
    START or STOP anywhere returns the slave to its entry point.
    The slave never stretches SCL.

  Latency, in clocks:
    Pins pass two synchroniser stages before any decision.
    A register write lands about three clocks after the SCL fall
    that ends its eighth bit; the path outputs follow one clock later.
    A flag sets one clock after the synchronised level moves and the
    interrupt follows one clock later.
    Reading offset 0x02 clears the flags as the byte is loaded; an
    event in that very cycle keeps its flag.

  Assumes the pins and analog comparator levels are asynchronous to
  clock and the host keeps each SCL phase at four clocks or more.
*/
//
// Contract
// RULE1: Both sink bits set force both sinks off
// RULE2: AC sink on if USB valid, AC low
// RULE3: USB sink on if AC valid, USB low
// RULE4: Host changes both sink bits together
// RULE5: Bit 5 switches AC input, resets one
// RULE6: Bit 4 switches USB input, resets one
// RULE7: Limit fields two bits, low bit fixed
// RULE8: Mask bit 6 gates button interrupt
// RULE9: Mask bit 5 gates AC interrupt
// RULE10: Mask bit 4 gates USB interrupt
// RULE11: Flag bit 2 sets on button change
// RULE12: Flag bit 1 sets on AC change
// RULE13: Flag bit 0 sets on USB change
// RULE14: Bit 7 reserved writable, bit 3 reads zero
// RULE15: Present levels readable in status register
// RULE16: Path register offset 1, reset 0x3d
// RULE17: Event register offset 2, reset 0x80
// RULE18: Unmasked flag drives interrupt, read clears
`timescale 1ns/1ps

module ppe_regs
  import ppe_pkg::*;
#(
  parameter logic [6:0] SLAVE_ADDR = PPE_I2C_ADDR
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic        sclIn,
  input  wire logic        sdaIn,
  output      logic        sdaOut,
  output      logic        sdaOeN,
  input  wire ppe_supply_s supplyIn,
  input  wire logic [7:0]  chargerStatus,
  output      ppe_path_s   pathOut,
  output      logic        eventIrqN
);

  // All state lives in one packed struct: the comb process builds the
  // next copy and the clocked process registers it. Every output thus
  // comes from a flip-flop, and no field can pick up a second driver.
  // Fields that a branch leaves alone simply keep their value.
  ppe_state_s st_r;
  ppe_state_s st_nxt;

  // Read mux over the mapped offsets; unmapped offsets read zero
  // Pure lookup with no side effects: the flag clear that goes with the
  // event byte is made by the caller at the load, so only a real read
  // by the host can clear anything.
  function automatic logic [7:0] readReg(input ppe_state_s s, input logic [7:0] ofs);
    logic [7:0] d;
    d = 8'h00;
    case (ofs)
      PPE_OFS_PATH:   d = s.pathReg;
      PPE_OFS_EVENT:  d = {s.evtHi, 1'b0, s.flags}; // RULE14
      PPE_OFS_CHG0:   d = s.sync2.chg;
      PPE_OFS_STATUS: begin
        d[PPE_STS_AC]  = s.sync2.supply.acValid;    // RULE15
        d[PPE_STS_USB] = s.sync2.supply.usbValid;   // RULE15
        d[PPE_STS_BTN] = s.sync2.supply.pushButton; // RULE15
      end
      default:        d = 8'h00;
    endcase
    return d;
  endfunction

  // Next-state logic for the whole block
  // Order matters below: framing may set clrFlags, and the flag update
  // after it must see that, so the flag merge follows the framing.
  // Each branch writes only the fields it owns; the rest hold.
  always_comb begin
    logic       sclRise;
    logic       sclFall;
    logic       startCond;
    logic       stopCond;
    logic [2:0] levelNow;
    logic [2:0] setFlags;
    logic       clrFlags;
    logic [7:0] wd;
    logic [7:0] rd;
    logic [2:0] unmasked;
    logic       bothSink;
    sclRise   = 1'b0;
    sclFall   = 1'b0;
    startCond = 1'b0;
    stopCond  = 1'b0;
    levelNow  = 3'h0;
    setFlags  = 3'h0;
    clrFlags  = 1'b0;
    wd        = 8'h00;
    rd        = 8'h00;
    unmasked  = 3'h0;
    bothSink  = 1'b0;
    st_nxt    = st_r;

    // Two-flop synchronisers; only the second stage feeds logic
    st_nxt.sync1 = {sclIn, sdaIn, supplyIn, chargerStatus};
    st_nxt.sync2 = st_r.sync1;
    st_nxt.sclD  = st_r.sync2.scl;
    st_nxt.sdaD  = st_r.sync2.sda;

    // Edges and START/STOP compare the second stage with one more stage,
    // so SCL and SDA are judged at the same age. This costs a clock of
    // latency but keeps a race between the two pins from faking a START.
    sclRise   = st_r.sync2.scl & ~st_r.sclD;
    sclFall   = ~st_r.sync2.scl & st_r.sclD;
    startCond = st_r.sync2.scl & st_r.sclD & st_r.sdaD & ~st_r.sync2.sda;
    stopCond  = st_r.sync2.scl & st_r.sclD & ~st_r.sdaD & st_r.sync2.sda;

    // Change detection; held off until the synchronisers hold real levels
    // The prime count covers the reset values still draining out of the
    // stages; without it every input that idles high would raise a
    // flag right after reset.
    levelNow = {st_r.sync2.supply.pushButton, st_r.sync2.supply.acValid,
                st_r.sync2.supply.usbValid};
    st_nxt.levelPrev = levelNow;
    if (st_r.prime != PPE_PRIME_CYCLES) begin
      st_nxt.prime = st_r.prime + 2'h1;
    end else begin
      setFlags[PPE_EVT_BTN_FLAG] = levelNow[2] ^ st_r.levelPrev[2]; // RULE11
      setFlags[PPE_EVT_AC_FLAG]  = levelNow[1] ^ st_r.levelPrev[1]; // RULE12
      setFlags[PPE_EVT_USB_FLAG] = levelNow[0] ^ st_r.levelPrev[0]; // RULE13
    end

    // Serial slave framing
    // STOP and START win over every state, so a host that gives up in
    // mid-frame always finds the slave back at its entry point.
    // Bits are taken on SCL rise and answers move on SCL fall, which
    // keeps SDA steady while SCL is high as the bus demands.
    // An address mismatch drops to idle and ignores the rest of the
    // frame until the next START.
    if (stopCond) begin
      st_nxt.fsm    = PPE_IDLE;
      st_nxt.sdaOeN = 1'b1;
    end else if (startCond) begin
      st_nxt.fsm    = PPE_ADDR;
      st_nxt.cnt    = 4'h0;
      st_nxt.sdaOeN = 1'b1;
    end else begin
      unique case (st_r.fsm)
        PPE_IDLE: begin
          st_nxt.sdaOeN = 1'b1;
        end
        PPE_ADDR, PPE_PTR, PPE_WDATA: begin
          if (sclRise) begin
            st_nxt.shift = {st_r.shift[6:0], st_r.sync2.sda};
            st_nxt.cnt   = st_r.cnt + 4'h1;
          end else if (sclFall && st_r.cnt == 4'h8) begin
            st_nxt.cnt = 4'h0;
            if (st_r.fsm == PPE_ADDR) begin
              if (st_r.shift[7:1] == SLAVE_ADDR) begin
                st_nxt.rw       = st_r.shift[0];
                st_nxt.sdaOeN   = 1'b0;
                st_nxt.fsm      = PPE_ACK;
                st_nxt.afterAck = st_r.shift[0] ? PPE_RDATA : PPE_PTR;
              end else begin
                st_nxt.fsm = PPE_IDLE;
              end
            end else if (st_r.fsm == PPE_PTR) begin
              st_nxt.ptr      = st_r.shift;
              st_nxt.sdaOeN   = 1'b0;
              st_nxt.fsm      = PPE_ACK;
              st_nxt.afterAck = PPE_WDATA;
            end else begin
              // Register write, pointer advances for burst writes
              wd = st_r.shift;
              if (st_r.ptr == PPE_OFS_PATH) begin // RULE16
                st_nxt.pathReg[7:4] = wd[7:4]; // RULE5 RULE6
                st_nxt.pathReg[3]   = wd[3];   // RULE7
                st_nxt.pathReg[1]   = wd[1];   // RULE7
              end else if (st_r.ptr == PPE_OFS_EVENT) begin // RULE17
                st_nxt.evtHi = wd[7:4]; // RULE8 RULE9 RULE10 RULE14
              end
              st_nxt.ptr      = st_r.ptr + 8'h01;
              st_nxt.sdaOeN   = 1'b0;
              st_nxt.fsm      = PPE_ACK;
              st_nxt.afterAck = PPE_WDATA;
            end
          end
        end
        PPE_ACK: begin
          // Acknowledge slot ends on the next falling SCL
          // For a read the first byte is loaded here, so its top bit is
          // on SDA well before the host raises SCL again.
          if (sclFall) begin
            st_nxt.cnt    = 4'h0;
            st_nxt.sdaOeN = 1'b1;
            st_nxt.fsm    = st_r.afterAck;
            if (st_r.afterAck == PPE_RDATA) begin
              rd = readReg(st_r, st_r.ptr);
              st_nxt.shift  = rd;
              st_nxt.sdaOeN = rd[7];
              st_nxt.ptr    = st_r.ptr + 8'h01;
              clrFlags      = (st_r.ptr == PPE_OFS_EVENT); // RULE18
            end
          end
        end
        // Read data: count rises, shift on falls; after the eighth bit
        // the line is released so the host can answer.
        // Only zero bits pull SDA; ones leave it to the pull-up.
        PPE_RDATA: begin
          if (sclRise) begin
            st_nxt.cnt = st_r.cnt + 4'h1;
          end else if (sclFall) begin
            if (st_r.cnt == 4'h8) begin
              st_nxt.sdaOeN = 1'b1;
              st_nxt.fsm    = PPE_MACK;
            end else begin
              st_nxt.shift  = {st_r.shift[6:0], 1'b0};
              st_nxt.sdaOeN = st_r.shift[6];
            end
          end
        end
        PPE_MACK: begin
          // Master acknowledge: low continues the burst, high ends it
          // The answer is latched on the rise and acted on at the fall,
          // when the next byte may be driven without a bus clash.
          if (sclRise) begin
            st_nxt.nacked = st_r.sync2.sda;
          end else if (sclFall) begin
            if (st_r.nacked) begin
              st_nxt.fsm = PPE_IDLE;
            end else begin
              rd = readReg(st_r, st_r.ptr);
              st_nxt.shift  = rd;
              st_nxt.sdaOeN = rd[7];
              st_nxt.ptr    = st_r.ptr + 8'h01;
              st_nxt.cnt    = 4'h0;
              st_nxt.fsm    = PPE_RDATA;
              clrFlags      = (st_r.ptr == PPE_OFS_EVENT); // RULE18
            end
          end
        end
      endcase
    end

    // A new event in the clearing cycle survives the clear
    // Losing it would hide a change that the host has not yet seen.
    st_nxt.flags = (clrFlags ? 3'h0 : st_r.flags) | setFlags; // RULE11 RULE12 RULE13

    // Interrupt from any flag whose mask is clear
    // Masks gate only the line; the flags themselves always record events.
    unmasked[PPE_EVT_BTN_FLAG] = st_r.flags[PPE_EVT_BTN_FLAG] &
                                 ~st_r.evtHi[PPE_EVT_BTN_MASK - 4]; // RULE8
    unmasked[PPE_EVT_AC_FLAG]  = st_r.flags[PPE_EVT_AC_FLAG] &
                                 ~st_r.evtHi[PPE_EVT_AC_MASK - 4];  // RULE9
    unmasked[PPE_EVT_USB_FLAG] = st_r.flags[PPE_EVT_USB_FLAG] &
                                 ~st_r.evtHi[PPE_EVT_USB_MASK - 4]; // RULE10
    st_nxt.irqN = ~(|unmasked); // RULE18

    // Sink control; mixed settings are left to the host to avoid
    // Sinks follow the synchronised comparator levels every clock, so a
    // supply that drops turns its partner sink off within a few clocks.
    // Both control bits set forces both sinks off whatever the supplies.
    // A mixed pair is honoured bit by bit and may toggle unexpectedly.
    bothSink = st_r.pathReg[PPE_PATH_AC_CURRENT_SINK_CTRL] & st_r.pathReg[PPE_PATH_USB_CURRENT_SINK_CTRL]; // RULE4
    st_nxt.path.acSinkEn  = ~bothSink & ~st_r.pathReg[PPE_PATH_AC_CURRENT_SINK_CTRL] &
                            st_r.sync2.supply.usbValid & st_r.sync2.supply.acBelowThr;  // RULE1 RULE2
    st_nxt.path.usbSinkEn = ~bothSink & ~st_r.pathReg[PPE_PATH_USB_CURRENT_SINK_CTRL] &
                            st_r.sync2.supply.acValid & st_r.sync2.supply.usbBelowThr;  // RULE1 RULE3
    st_nxt.path.acPathOn        = st_r.pathReg[PPE_PATH_ACON];  // RULE5
    st_nxt.path.usbPathOn       = st_r.pathReg[PPE_PATH_USBON]; // RULE6
    st_nxt.path.acCurrentLimit  = st_r.pathReg[PPE_PATH_IAC_LO +: 2];  // RULE7
    st_nxt.path.usbCurrentLimit = st_r.pathReg[PPE_PATH_USB_CURRENT_LIMIT_LO +: 2]; // RULE7
    st_nxt.sdaOut = 1'b0; // Open drain: only ever pulls low
  end

  // State register; reset loads constants only
  // The reset is synchronous, so outputs take their reset values at
  // the first clock edge with rst high, not before.
  // Synchroniser stages reset to the idle bus level to avoid a false START.
  always_ff @(posedge clock) begin
    if (rst) begin
      st_r          <= '0;
      st_r.sync1    <= '{scl: 1'b1, sda: 1'b1, supply: '0, chg: 8'h00};
      st_r.sync2    <= '{scl: 1'b1, sda: 1'b1, supply: '0, chg: 8'h00};
      st_r.sclD     <= 1'b1;
      st_r.sdaD     <= 1'b1;
      st_r.fsm      <= PPE_IDLE;
      st_r.afterAck <= PPE_IDLE;
      st_r.pathReg  <= PPE_RST_PATH;       // RULE16
      st_r.evtHi    <= PPE_RST_EVENT[7:4]; // RULE17
      st_r.path     <= '{acSinkEn: 1'b0, usbSinkEn: 1'b0,
                         acPathOn: PPE_RST_PATH[PPE_PATH_ACON],
                         usbPathOn: PPE_RST_PATH[PPE_PATH_USBON],
                         acCurrentLimit: PPE_RST_PATH[PPE_PATH_IAC_LO +: 2],
                         usbCurrentLimit: PPE_RST_PATH[PPE_PATH_USB_CURRENT_LIMIT_LO +: 2]};
      st_r.irqN     <= 1'b1;
      st_r.sdaOeN   <= 1'b1;
    end else begin
      st_r <= st_nxt;
    end
  end

  // Outputs come straight from the state register
  // sdaOut is a constant zero flip-flop: the line is only pulled low,
  // and sdaOeN alone decides when.
  assign sdaOut    = st_r.sdaOut;
  assign sdaOeN    = st_r.sdaOeN;
  assign pathOut   = st_r.path;
  assign eventIrqN = st_r.irqN;

endmodule

//--- hdl/ppe_pkg.sv
/*
  Package for the power path and event register bank: register offsets,
  field positions, reset values, I2C framing states and the packed carriers.
  Assumes a single 250 MHz clock domain and a synchronous active-high reset.
*/
package ppe_pkg;

  // Register offsets as seen through the serial register pointer
  localparam logic [7:0] PPE_OFS_PATH   = 8'h01;
  localparam logic [7:0] PPE_OFS_EVENT  = 8'h02;
  localparam logic [7:0] PPE_OFS_CHG0   = 8'h03;
  localparam logic [7:0] PPE_OFS_STATUS = 8'h0a;

  // Reset values
  localparam logic [7:0] PPE_RST_PATH   = 8'h3d;
  localparam logic [7:0] PPE_RST_EVENT  = 8'h80;

  // Power path control fields
  localparam int PPE_PATH_AC_CURRENT_SINK_CTRL  = 7;
  localparam int PPE_PATH_USB_CURRENT_SINK_CTRL = 6;
  localparam int PPE_PATH_ACON    = 5;
  localparam int PPE_PATH_USBON   = 4;
  localparam int PPE_PATH_IAC_LO  = 2;
  localparam int PPE_PATH_USB_CURRENT_LIMIT_LO = 0;

  // Event flag and mask fields
  localparam int PPE_EVT_RSV_RW   = 7;
  localparam int PPE_EVT_BTN_MASK = 6;
  localparam int PPE_EVT_AC_MASK  = 5;
  localparam int PPE_EVT_USB_MASK = 4;
  localparam int PPE_EVT_BTN_FLAG = 2;
  localparam int PPE_EVT_AC_FLAG  = 1;
  localparam int PPE_EVT_USB_FLAG = 0;

  // Status register fields (present levels)
  localparam int PPE_STS_AC  = 3;
  localparam int PPE_STS_USB = 2;
  localparam int PPE_STS_BTN = 0;

  // Default 7-bit slave address; value is arbitrary
  localparam logic [6:0] PPE_I2C_ADDR = 7'h30;

  // Cycles after reset before level changes count as events
  localparam logic [1:0] PPE_PRIME_CYCLES = 2'h3;

  typedef enum logic [2:0] {
    PPE_IDLE,
    PPE_ADDR,
    PPE_PTR,
    PPE_WDATA,
    PPE_RDATA,
    PPE_ACK,
    PPE_MACK
  } ppe_i2c_e;

  // Analog comparator and pin levels entering the block
  typedef struct packed {
    logic pushButton;
    logic acValid;
    logic usbValid;
    logic acBelowThr;
    logic usbBelowThr;
  } ppe_supply_s;

  // Power path controls leaving the block
  typedef struct packed {
    logic       acSinkEn;
    logic       usbSinkEn;
    logic       acPathOn;
    logic       usbPathOn;
    logic [1:0] acCurrentLimit;
    logic [1:0] usbCurrentLimit;
  } ppe_path_s;

  // Everything that crosses in from outside the clock domain
  typedef struct packed {
    logic        scl;
    logic        sda;
    ppe_supply_s supply;
    logic [7:0]  chg;
  } ppe_pins_s;

  typedef struct packed {
    ppe_pins_s   sync1;
    ppe_pins_s   sync2;
    logic        sclD;
    logic        sdaD;
    logic [2:0]  levelPrev;
    logic [1:0]  prime;
    ppe_i2c_e    fsm;
    ppe_i2c_e    afterAck;
    logic [3:0]  cnt;
    logic [7:0]  shift;
    logic        rw;
    logic [7:0]  ptr;
    logic        nacked;
    logic [7:0]  pathReg;
    logic [3:0]  evtHi;
    logic [2:0]  flags;
    ppe_path_s   path;
    logic        irqN;
    logic        sdaOeN;
    logic        sdaOut;
  } ppe_state_s;

endpackage

//--- tb/ppe_regs_sva.sv
/*
  Port checker for the power path and event register bank.
  Assumes one clock domain and is bound to every ppe_regs instance.
*/
`timescale 1ns/1ps
module ppe_regs_sva
  import ppe_pkg::*;
(
  input wire logic        clock,
  input wire logic        rst,
  input wire logic        sclIn,
  input wire ppe_supply_s supplyIn,
  input wire ppe_path_s   pathOut,
  input wire logic        eventIrqN
);
  logic       sclD_r;
  logic [2:0] supD_r;
  logic [3:0] sclQuiet_r;
  logic [3:0] supQuiet_r;

  // Saturating idle counts; bus and supply moves are the only legal causes
  always_ff @(posedge clock) begin
    sclD_r     <= sclIn;
    supD_r     <= supplyIn[4:2];
    if (rst) begin
      sclQuiet_r <= 4'h0;
      supQuiet_r <= 4'h0;
    end else begin
      sclQuiet_r <= (sclIn != sclD_r) ? 4'h0 : sclQuiet_r + {3'h0, sclQuiet_r != 4'hf};
      supQuiet_r <= (supplyIn[4:2] != supD_r) ? 4'h0 : supQuiet_r + {3'h0, supQuiet_r != 4'hf};
    end
  end

  default clocking cb @(posedge clock); endclocking
  default disable iff (rst);

  AST_AC_SINK: assert property (pathOut.acSinkEn |->
    $past(supplyIn.usbValid, 3) && $past(supplyIn.acBelowThr, 3))
    else $error("ac sink on without its supply condition");
  AST_USB_SINK: assert property (pathOut.usbSinkEn |->
    $past(supplyIn.acValid, 3) && $past(supplyIn.usbBelowThr, 3))
    else $error("usb sink on without its supply condition");
  AST_RST_PATH: assert property (disable iff (1'b0) rst |=> pathOut == PPE_RST_PATH)
    else $error("path outputs not at reset value");
  AST_RST_IRQ: assert property (disable iff (1'b0) rst |=> eventIrqN)
    else $error("interrupt active after reset");
  AST_LIMIT_LOW: assert property (pathOut.acCurrentLimit[0] && pathOut.usbCurrentLimit[0])
    else $error("limit low bit not one");
  AST_IRQ_HOLD: assert property (!eventIrqN && sclQuiet_r == 4'hf |=> !eventIrqN)
    else $error("interrupt cleared without a read");
  AST_PATH_HOLD: assert property (sclQuiet_r == 4'hf |=> $stable(pathOut[5:0]))
    else $error("path setting moved without a write");
  AST_IRQ_CAUSE: assert property ($fell(eventIrqN) |->
    sclQuiet_r != 4'hf || supQuiet_r != 4'hf)
    else $error("interrupt raised without an event");
endmodule

bind ppe_regs ppe_regs_sva chk (.*);

//--- tb/ppe_host_model.sv
/*
  Host processor model: I2C master on an open-drain SDA with pull-up.
  Assumes the clock of the bench; each data bit holds SCL high for 8 clocks and low for 16.
*/
`timescale 1ns/1ps
module ppe_host_model (
  input  wire logic clock,
  input  wire logic sdaOeN,
  input  wire logic sdaOut,
  output      logic scl,
  output      logic sda
);
  logic drv;

  // Wired-AND line; released means pulled up, never the last value
  assign sda = drv & (sdaOeN | sdaOut);

  initial begin
    scl = 1'b1;
    drv = 1'b1;
  end

  task automatic hold();
    repeat (8) @(posedge clock);
    #1;
  endtask

  // Also serves as repeated start from SCL low
  task automatic start();
    drv = 1'b1;
    hold();
    scl = 1'b1;
    hold();
    drv = 1'b0;
    hold();
    scl = 1'b0;
    hold();
  endtask

  task automatic stop();
    drv = 1'b0;
    hold();
    scl = 1'b1;
    hold();
    drv = 1'b1;
    hold();
  endtask

  // Nine bits MSB first; a 1 releases the line so the slave can answer
  task automatic xfer(input logic [8:0] tx, output logic [8:0] rx);
    for (int i = 8; i >= 0; i--) begin
      drv = tx[i];
      hold();
      scl = 1'b1;
      hold();
      rx[i] = sda;
      scl = 1'b0;
      hold();
    end
  endtask
endmodule

//--- tb/ppe_regs_tb_top.sv
/*
  Self-checking bench for ppe_regs with a host model on the serial bus.
  Assumes the checker is bound from its own file.
*/
`timescale 1ns/1ps
module ppe_regs_tb_top
  import ppe_pkg::*;
;
  logic        clock;
  logic        rst;
  logic        scl;
  logic        sda;
  logic        sdaOut;
  logic        sdaOeN;
  ppe_supply_s supply;
  logic [7:0]  chgSts;
  ppe_path_s   pathOut;
  logic        irqN;
  logic [7:0]  rdVal;
  logic [8:0]  r9;
  logic [31:0] rows [6];
  int          num_errors;
  int          checked;
  int          cycles;

  ppe_regs uut (
    .clock         (clock),
    .rst           (rst),
    .sclIn         (scl),
    .sdaIn         (sda),
    .sdaOut        (sdaOut),
    .sdaOeN        (sdaOeN),
    .supplyIn      (supply),
    .chargerStatus (chgSts),
    .pathOut       (pathOut),
    .eventIrqN     (irqN)
  );

  ppe_host_model host (
    .clock  (clock),
    .sdaOeN (sdaOeN),
    .sdaOut (sdaOut),
    .scl    (scl),
    .sda    (sda)
  );

  initial begin
    clock = 1'b0;
    forever #2 clock = ~clock;
  end

  // Hang guard, far above the roughly 30k cycles the run needs
  always @(posedge clock) begin
    cycles++;
    if (cycles == 60000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic check(string what, logic [7:0] exp, logic [7:0] got);
    checked++;
    if (got !== exp) begin
      num_errors++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic wr(logic [7:0] ofs, logic [7:0] d);
    host.start();
    host.xfer({PPE_I2C_ADDR, 2'b01}, r9);
    host.xfer({ofs, 1'b1}, r9);
    host.xfer({d, 1'b1}, r9);
    check("ack", 8'h00, {7'h0, r9[0]});
    host.stop();
  endtask

  // Pointer write, repeated start, one byte, then NACK
  task automatic rd(logic [7:0] ofs);
    host.start();
    host.xfer({PPE_I2C_ADDR, 2'b01}, r9);
    host.xfer({ofs, 1'b1}, r9);
    host.start();
    host.xfer({PPE_I2C_ADDR, 2'b11}, r9);
    host.xfer(9'h1ff, r9);
    rdVal = r9[8:1];
    host.stop();
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, num_errors);
    if (num_errors == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask

  // Rows: offset, write data, read back, path outputs; sink bits move as pairs
  initial begin
    rows = '{32'h01_00_05_c5, 32'h01_fa_ff_3f, 32'h01_28_2d_ed,
             32'h01_d0_d5_15, 32'h02_7f_70_15, 32'h02_80_80_15};
    rst = 1'b1;
    supply = 5'b01111;
    chgSts = 8'h5a;
    repeat (4) @(posedge clock);
    #1 rst = 1'b0;
    repeat (8) @(posedge clock);
    #1;
    check("pathOut", 8'hfd, pathOut);
    check("irqRst", 8'h01, {7'h0, irqN});
    rd(PPE_OFS_PATH);
    check("path", PPE_RST_PATH, rdVal);
    rd(PPE_OFS_EVENT);
    check("event", PPE_RST_EVENT, rdVal);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i][31:24], rows[i][23:16]);
      rd(rows[i][31:24]);
      check("readback", rows[i][15:8], rdVal);
      check("pathOut", rows[i][7:0], pathOut);
    end
    $display("row test done");
    // Each source once masked, once unmasked, toggling both ways
    for (int k = 0; k < 3; k++) begin
      wr(PPE_OFS_EVENT, 8'h80 | (8'h10 << k));
      supply[k+2] = ~supply[k+2];
      repeat (10) @(posedge clock);
      #1;
      check("irqMasked", 8'h01, {7'h0, irqN});
      rd(PPE_OFS_EVENT);
      check("flag", 8'h80 | (8'h10 << k) | (8'h01 << k), rdVal);
      wr(PPE_OFS_EVENT, 8'h80);
      supply[k+2] = ~supply[k+2];
      repeat (10) @(posedge clock);
      #1;
      check("irq", 8'h00, {7'h0, irqN});
      rd(PPE_OFS_EVENT);
      check("flag", 8'h80 | (8'h01 << k), rdVal);
      check("irqClr", 8'h01, {7'h0, irqN});
    end
    $display("event test done");
    rd(PPE_OFS_STATUS);
    check("status", 8'h0c, rdVal);
    rd(PPE_OFS_CHG0);
    check("charger", chgSts, rdVal);
    wr(8'h05, 8'hff);
    rd(8'h05);
    check("unmapped", 8'h00, rdVal);
    host.start();
    host.xfer({~PPE_I2C_ADDR, 2'b01}, r9);
    host.stop();
    check("nack", 8'h01, {7'h0, r9[0]});
    // Burst write of two bytes, then a burst read with a master ACK between
    host.start();
    host.xfer({PPE_I2C_ADDR, 2'b01}, r9);
    host.xfer({PPE_OFS_PATH, 1'b1}, r9);
    host.xfer({8'hc0, 1'b1}, r9);
    host.xfer({8'h90, 1'b1}, r9);
    host.stop();
    host.start();
    host.xfer({PPE_I2C_ADDR, 2'b01}, r9);
    host.xfer({PPE_OFS_PATH, 1'b1}, r9);
    host.start();
    host.xfer({PPE_I2C_ADDR, 2'b11}, r9);
    host.xfer(9'h1fe, r9);
    check("burstPath", 8'hc5, r9[8:1]);
    host.xfer(9'h1ff, r9);
    host.stop();
    check("burstEvent", 8'h90, r9[8:1]);
    rst = 1'b1;
    repeat (2) @(posedge clock);
    #1 rst = 1'b0;
    repeat (8) @(posedge clock);
    #1;
    check("pathOutRst", 8'hfd, pathOut);
    check("irqRst", 8'h01, {7'h0, irqN});
    rd(PPE_OFS_PATH);
    check("path", PPE_RST_PATH, rdVal);
    $display("misc test done");
    end_of_test();
  end
endmodule
